// ### testbench/amsf_servo_model.sv
`timescale 1ns/1ps

// ----------------------------------------
// Amplifier side of each axis
// ----------------------------------------
module amsf_servo_model (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic op_cycle_tick,
  input wire logic [31:0] loop_change_command,
  output logic [31:0] amp_loop_state
);
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      amp_loop_state <= 32'h00000000;
    end else if (op_cycle_tick) begin
      amp_loop_state <= loop_change_command;
    end
  end
endmodule

// ### testbench/axis_motion_status_flags_tb_top.sv
`timescale 1ns/1ps

module axis_motion_status_flags_tb_top;
  logic sys_clk = 0, rst = 1, op_cycle_tick = 0, avs_read = 0, avs_write = 0;
  logic [31:0] program_speed_change_instruction = 0, plc_side_speed_change_instruction = 0;
  logic [31:0] zero_speed_request = 0, axis_started = 0, auto_decel_phase = 0, followup_mode = 0;
  logic [31:0] const_speed_mode = 0, final_point = 0, jog_release_decel = 0, pulse_generator_active = 0;
  logic [31:0] stop_decel = 0, zero_travel = 0, command_address_change = 0, start_complete = 0;
  logic [31:0] stop_cause_done = 0, interp_active = 0, avs_writedata = 0, avs_readdata, m, s, rd;
  logic [5:0] avs_address = 0;
  logic avs_waitrequest, irq;
  logic [31:0] speed_change_accepted_flag, auto_decelerating_flag, zero_speed_accepted_flag;
  logic [31:0] loop_mode_monitor_flag, loop_change_command, start_accepted_flag, restart_inhibit, amp_loop;
  int mismatches = 0, checked = 0, cycles = 0;

  // ----------------------------------------
  // Clock, timeout, instances
  // ----------------------------------------
  always #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      report_and_stop();
    end
  end
  amsf_status_flags uut (.sys_clk, .rst, .op_cycle_tick, .program_speed_change_instruction,
    .plc_side_speed_change_instruction, .zero_speed_request, .axis_started, .auto_decel_phase,
    .followup_mode, .const_speed_mode, .final_point, .jog_release_decel, .pulse_generator_active,
    .stop_decel, .zero_travel, .command_address_change, .start_complete, .stop_cause_done, .interp_active,
    .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest,
    .speed_change_accepted_flag, .auto_decelerating_flag, .zero_speed_accepted_flag,
    .loop_mode_monitor_flag, .loop_change_command, .start_accepted_flag, .restart_inhibit, .irq);
  amsf_servo_model partner (.sys_clk, .rst, .op_cycle_tick, .loop_change_command,
    .amp_loop_state(amp_loop));

  // ----------------------------------------
  // Expectation helpers and checks
  // ----------------------------------------
  function automatic logic [31:0] lowest_axis(input logic [31:0] v);
    return v & (~v + 32'h00000001);
  endfunction
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic tick();
    op_cycle_tick <= 1'b1;
    @(posedge sys_clk);
    op_cycle_tick <= 1'b0;
    // Flags launched at the tick edge are read one edge later
    @(posedge sys_clk);
  endtask
  // Avalon master: hold request until waitrequest sampled low
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d, output logic [31:0] q);
    logic done;
    done = 1'b0;
    q = 32'h00000000;
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !wr;
    avs_write <= wr;
    // Sample waitrequest and read data at the rising edge only
    while (!done) begin
      @(posedge sys_clk);
      done = (avs_waitrequest === 1'b0);
      q = avs_readdata;
    end
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic report_and_stop();
    $display("Counts: %0d checked, %0d mismatches", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(32'h441E));
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    chk("reset flags", 32'h00000000, speed_change_accepted_flag | zero_speed_accepted_flag);
    chk("reset wait", 32'h00000001, {31'h0, avs_waitrequest});
    bus(0, amsf_pkg::REG_VARIANT, 0, rd);
    chk("variant", 32'h00000000, rd);
    $display("Test reset done");
    // Program change sets, PLC change does not
    axis_started <= 32'hFFFFFFFF;
    m = $urandom;
    program_speed_change_instruction <= m;
    tick();
    program_speed_change_instruction <= 0;
    chk("spd prog", m, speed_change_accepted_flag);
    bus(0, amsf_pkg::REG_SPD_CHG, 0, rd);
    chk("spd reg", m, rd);
    plc_side_speed_change_instruction <= ~m;
    tick();
    plc_side_speed_change_instruction <= 0;
    chk("spd plc", m, speed_change_accepted_flag);
    $display("Test speed change done");
    // Auto deceleration: final point, suppress cases, follow-up, completion
    auto_decel_phase <= 32'hFFFFFFFF;
    const_speed_mode <= 32'hFFFFFFFF;
    final_point <= m;
    tick();
    chk("decel final", m, auto_decelerating_flag);
    final_point <= 32'hFFFFFFFF;
    for (int i = 0; i < 4; i++) begin
      s = $urandom;
      jog_release_decel <= (i == 0) ? s : 0;
      pulse_generator_active <= (i == 1) ? s : 0;
      stop_decel <= (i == 2) ? s : 0;
      zero_travel <= (i == 3) ? s : 0;
      tick();
      chk("decel suppress", ~s, auto_decelerating_flag);
    end
    stop_decel <= 0;
    zero_travel <= 0;
    const_speed_mode <= 0;
    followup_mode <= 32'hFFFFFFFF;
    tick();
    chk("decel follow", 32'hFFFFFFFF, auto_decelerating_flag);
    command_address_change <= m;
    tick();
    command_address_change <= 0;
    chk("decel addr", ~m, auto_decelerating_flag);
    start_complete <= 32'hFFFFFFFF;
    tick();
    start_complete <= 0;
    chk("decel done", 32'h00000000, auto_decelerating_flag);
    // Zero request accepted after follow-up deceleration start
    tick();
    chk("decel again", 32'hFFFFFFFF, auto_decelerating_flag);
    zero_speed_request <= 32'hFFFFFFFF;
    tick();
    chk("zero follow", 32'hFFFFFFFF, zero_speed_accepted_flag);
    zero_speed_request <= 0;
    auto_decel_phase <= 0;
    followup_mode <= 0;
    stop_cause_done <= 32'hFFFFFFFF;
    tick();
    stop_cause_done <= 0;
    chk("zero stop", 32'h00000000, zero_speed_accepted_flag);
    $display("Test deceleration done");
    // Zero request hold, restart inhibit, later change clears
    zero_speed_request <= m;
    tick();
    zero_speed_request <= 0;
    axis_started <= 0;
    command_address_change <= 32'hFFFFFFFF;
    tick();
    command_address_change <= 0;
    chk("zero set", m, zero_speed_accepted_flag);
    chk("start acc", m, start_accepted_flag);
    chk("inhibit", m, restart_inhibit);
    axis_started <= 32'hFFFFFFFF;
    plc_side_speed_change_instruction <= m;
    tick();
    plc_side_speed_change_instruction <= 0;
    chk("zero clr", 32'h00000000, zero_speed_accepted_flag);
    stop_decel <= m;
    zero_speed_request <= 32'hFFFFFFFF;
    tick();
    chk("zero block", ~m, zero_speed_accepted_flag);
    zero_speed_request <= 0;
    stop_decel <= 0;
    stop_cause_done <= 32'hFFFFFFFF;
    tick();
    stop_cause_done <= 0;
    interp_active <= m;
    zero_speed_request <= lowest_axis(m);
    tick();
    zero_speed_request <= 0;
    chk("zero interp", m, zero_speed_accepted_flag);
    $display("Test zero speed done");
    // Loop command reaches monitor and amplifier
    s = $urandom;
    bus(1, amsf_pkg::REG_LOOP_CMD, s, rd);
    tick();
    chk("loop cmd", s, loop_change_command);
    chk("loop mon", s, loop_mode_monitor_flag);
    chk("amp loop", s, amp_loop);
    // Interrupt raise, mask, clear, unmapped read
    bus(1, amsf_pkg::REG_IRQ_CLEAR, 32'h0000000F, rd);
    bus(1, amsf_pkg::REG_IRQ_ENABLE, 32'h00000001, rd);
    axis_started <= 0;
    tick();
    axis_started <= 32'hFFFFFFFF;
    program_speed_change_instruction <= 32'h00000001;
    tick();
    program_speed_change_instruction <= 0;
    chk("irq on", 32'h00000001, {31'h0, irq});
    bus(1, amsf_pkg::REG_IRQ_ENABLE, 0, rd);
    @(posedge sys_clk);
    chk("irq mask", 32'h00000000, {31'h0, irq});
    bus(1, amsf_pkg::REG_IRQ_CLEAR, 32'h0000000F, rd);
    bus(0, amsf_pkg::REG_IRQ_STATUS, 0, rd);
    chk("irq clr", 32'h00000000, rd);
    bus(0, 6'h3C, 0, rd);
    chk("unmapped", 32'h00000000, rd);
    // Eight-axis variant masks upper axes
    bus(1, amsf_pkg::REG_VARIANT, {30'h0, amsf_pkg::VARIANT_8}, rd);
    program_speed_change_instruction <= 32'hFFFFFFFF;
    tick();
    program_speed_change_instruction <= 0;
    chk("variant 8", amsf_pkg::MASK_8, speed_change_accepted_flag);
    $display("Test registers done");
    report_and_stop();
  end
endmodule

// ### verilog/amsf_pkg.sv
package amsf_pkg;

  // ----------------------------------------
  // Sizes
  // ----------------------------------------
  localparam int AXES = 32;
  localparam int ADDR_W = 6;
  localparam int DATA_W = 32;
  localparam int IRQ_W = 4;

  // ----------------------------------------
  // Register byte offsets
  // ----------------------------------------
  localparam logic [ADDR_W-1:0] REG_SPD_CHG = 6'h00;
  localparam logic [ADDR_W-1:0] REG_AUTO_DECEL = 6'h04;
  localparam logic [ADDR_W-1:0] REG_ZERO_SPD = 6'h08;
  localparam logic [ADDR_W-1:0] REG_LOOP_MON = 6'h0C;
  localparam logic [ADDR_W-1:0] REG_LOOP_CMD = 6'h10;
  localparam logic [ADDR_W-1:0] REG_VARIANT = 6'h14;
  localparam logic [ADDR_W-1:0] REG_IRQ_STATUS = 6'h18;
  localparam logic [ADDR_W-1:0] REG_IRQ_ENABLE = 6'h1C;
  localparam logic [ADDR_W-1:0] REG_IRQ_CLEAR = 6'h20;
  localparam logic [ADDR_W-1:0] REG_START_ACC = 6'h24;

  // ----------------------------------------
  // Axis count variants and valid masks
  // ----------------------------------------
  localparam logic [1:0] VARIANT_32 = 2'h0;
  localparam logic [1:0] VARIANT_16 = 2'h1;
  localparam logic [1:0] VARIANT_8 = 2'h2;
  localparam logic [AXES-1:0] MASK_32 = 32'hFFFFFFFF;
  localparam logic [AXES-1:0] MASK_16 = 32'h0000FFFF;
  localparam logic [AXES-1:0] MASK_8 = 32'h000000FF;

  // ----------------------------------------
  // Interrupt status bit positions
  // ----------------------------------------
  localparam int IRQ_SPD_CHG = 0;
  localparam int IRQ_AUTO_DECEL = 1;
  localparam int IRQ_ZERO_SPD = 2;
  localparam int IRQ_LOOP = 3;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [AXES-1:0] AXES_CLEAR = 32'h00000000;
  localparam logic [IRQ_W-1:0] IRQ_CLEAR_VAL = 4'h0;
  localparam logic [DATA_W-1:0] DATA_ZERO = 32'h00000000;

endpackage

// ### verilog/amsf_status_flags.sv
// Implementation choices: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/1ps

module amsf_status_flags (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic op_cycle_tick,
  input wire logic [amsf_pkg::AXES-1:0] program_speed_change_instruction,
  input wire logic [amsf_pkg::AXES-1:0] plc_side_speed_change_instruction,
  input wire logic [amsf_pkg::AXES-1:0] zero_speed_request,
  input wire logic [amsf_pkg::AXES-1:0] axis_started,
  input wire logic [amsf_pkg::AXES-1:0] auto_decel_phase,
  input wire logic [amsf_pkg::AXES-1:0] followup_mode,
  input wire logic [amsf_pkg::AXES-1:0] const_speed_mode,
  input wire logic [amsf_pkg::AXES-1:0] final_point,
  input wire logic [amsf_pkg::AXES-1:0] jog_release_decel,
  input wire logic [amsf_pkg::AXES-1:0] pulse_generator_active,
  input wire logic [amsf_pkg::AXES-1:0] stop_decel,
  input wire logic [amsf_pkg::AXES-1:0] zero_travel,
  input wire logic [amsf_pkg::AXES-1:0] command_address_change,
  input wire logic [amsf_pkg::AXES-1:0] start_complete,
  input wire logic [amsf_pkg::AXES-1:0] stop_cause_done,
  input wire logic [amsf_pkg::AXES-1:0] interp_active,
  input wire logic [amsf_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [amsf_pkg::DATA_W-1:0] avs_writedata,
  output logic [amsf_pkg::DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  output logic [amsf_pkg::AXES-1:0] speed_change_accepted_flag,
  output logic [amsf_pkg::AXES-1:0] auto_decelerating_flag,
  output logic [amsf_pkg::AXES-1:0] zero_speed_accepted_flag,
  output logic [amsf_pkg::AXES-1:0] loop_mode_monitor_flag,
  output logic [amsf_pkg::AXES-1:0] loop_change_command,
  output logic [amsf_pkg::AXES-1:0] start_accepted_flag,
  output logic [amsf_pkg::AXES-1:0] restart_inhibit,
  output logic irq
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef enum logic [1:0] {
    AMSF_BUS_IDLE = 2'b01,
    AMSF_BUS_ANSWER = 2'b10
  } amsf_bus_t;

  typedef struct packed {
    amsf_bus_t bus;
    logic wait_req;
    logic [amsf_pkg::DATA_W-1:0] rdata;
    logic [amsf_pkg::AXES-1:0] spd;
    logic [amsf_pkg::AXES-1:0] decel;
    logic [amsf_pkg::AXES-1:0] zero;
    logic [amsf_pkg::AXES-1:0] loop_mon;
    logic [amsf_pkg::AXES-1:0] loop_cmd;
    logic [amsf_pkg::AXES-1:0] start_acc;
    logic [amsf_pkg::AXES-1:0] inhibit;
    logic [1:0] variant;
    logic [amsf_pkg::IRQ_W-1:0] status;
    logic [amsf_pkg::IRQ_W-1:0] enable;
    logic irq;
  } amsf_state_t;

  amsf_state_t state_reg;
  amsf_state_t state_next;

  // Valid axes for the selected variant
  function automatic logic [amsf_pkg::AXES-1:0] axis_mask(input logic [1:0] variant);
    logic [amsf_pkg::AXES-1:0] m;
    m = amsf_pkg::MASK_32;
    if (variant == amsf_pkg::VARIANT_16) begin
      m = amsf_pkg::MASK_16;
    end else if (variant == amsf_pkg::VARIANT_8) begin
      m = amsf_pkg::MASK_8;
    end
    return m;
  endfunction

  // Any newly raised flag
  function automatic logic rose(input logic [amsf_pkg::AXES-1:0] now, input logic [amsf_pkg::AXES-1:0] was);
    return |(now & ~was);
  endfunction

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  always_comb begin
    logic [amsf_pkg::AXES-1:0] mask;
    logic [amsf_pkg::AXES-1:0] qual;
    logic [amsf_pkg::AXES-1:0] kill;
    logic [amsf_pkg::AXES-1:0] block;
    logic [amsf_pkg::AXES-1:0] acc;
    logic [amsf_pkg::AXES-1:0] grp;
    logic [amsf_pkg::AXES-1:0] zclr;
    logic [amsf_pkg::IRQ_W-1:0] ev;
    logic [amsf_pkg::IRQ_W-1:0] clr;
    logic commit;
    mask = axis_mask(state_reg.variant);
    qual = '0;
    kill = '0;
    block = '0;
    acc = '0;
    grp = '0;
    zclr = '0;
    ev = '0;
    clr = '0;
    commit = 1'b0;
    state_next = state_reg;

    // Flag update once per operation cycle
    // per-cycle update
    if (op_cycle_tick) begin
      state_next.spd = ((state_reg.spd & axis_started) | program_speed_change_instruction) & mask;

      qual = auto_decel_phase & (~const_speed_mode | final_point)
             & ~(jog_release_decel | pulse_generator_active | stop_decel | zero_travel);
      kill = (followup_mode & command_address_change) | start_complete;
      state_next.decel = qual & ~kill & mask;

      block = jog_release_decel | stop_decel | (state_reg.decel & ~followup_mode);
      acc = zero_speed_request & axis_started & ~block;
      grp = (|(acc & interp_active)) ? interp_active : amsf_pkg::AXES_CLEAR;
      zclr = ((program_speed_change_instruction | plc_side_speed_change_instruction) & ~zero_speed_request)
             | stop_cause_done;
      state_next.zero = ((state_reg.zero & ~zclr) | acc | grp) & mask;

      state_next.start_acc = (axis_started | state_next.zero) & mask;
      state_next.inhibit = state_next.zero & mask;
      state_next.loop_mon = state_reg.loop_cmd & mask;
    end

    // Avalon handshake: answer one cycle after request
    commit = 1'b0;
    unique case (state_reg.bus)
      AMSF_BUS_IDLE: begin
        state_next.wait_req = 1'b1;
        if (avs_read || avs_write) begin
          state_next.bus = AMSF_BUS_ANSWER;
          state_next.wait_req = 1'b0;
          unique case (avs_address)
            amsf_pkg::REG_SPD_CHG: state_next.rdata = state_reg.spd;
            amsf_pkg::REG_AUTO_DECEL: state_next.rdata = state_reg.decel;
            amsf_pkg::REG_ZERO_SPD: state_next.rdata = state_reg.zero;
            amsf_pkg::REG_LOOP_MON: state_next.rdata = state_reg.loop_mon;
            amsf_pkg::REG_LOOP_CMD: state_next.rdata = state_reg.loop_cmd;
            amsf_pkg::REG_VARIANT: state_next.rdata = {30'h0, state_reg.variant};
            amsf_pkg::REG_IRQ_STATUS: state_next.rdata = {28'h0000000, state_reg.status};
            amsf_pkg::REG_IRQ_ENABLE: state_next.rdata = {28'h0000000, state_reg.enable};
            amsf_pkg::REG_START_ACC: state_next.rdata = state_reg.start_acc;
            default: state_next.rdata = amsf_pkg::DATA_ZERO;
          endcase
        end
      end
      AMSF_BUS_ANSWER: begin
        state_next.bus = AMSF_BUS_IDLE;
        state_next.wait_req = 1'b1;
        commit = avs_write;
      end
      default: begin
        state_next.bus = AMSF_BUS_IDLE;
        state_next.wait_req = 1'b1;
      end
    endcase

    // Register writes take effect on the accepting edge
    if (commit) begin
      unique case (avs_address)
        amsf_pkg::REG_LOOP_CMD: state_next.loop_cmd = avs_writedata;
        amsf_pkg::REG_VARIANT: state_next.variant = avs_writedata[1:0];
        amsf_pkg::REG_IRQ_ENABLE: state_next.enable = avs_writedata[amsf_pkg::IRQ_W-1:0];
        amsf_pkg::REG_IRQ_CLEAR: clr = avs_writedata[amsf_pkg::IRQ_W-1:0];
        default: clr = '0;
      endcase
    end

    // Sticky events, set wins over clear
    ev[amsf_pkg::IRQ_SPD_CHG] = rose(state_next.spd, state_reg.spd);
    ev[amsf_pkg::IRQ_AUTO_DECEL] = rose(state_next.decel, state_reg.decel);
    ev[amsf_pkg::IRQ_ZERO_SPD] = rose(state_next.zero, state_reg.zero);
    ev[amsf_pkg::IRQ_LOOP] = |(state_next.loop_mon ^ state_reg.loop_mon);
    state_next.status = (state_reg.status & ~clr) | ev;
    state_next.irq = |(state_next.status & state_next.enable);
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_reg.bus <= AMSF_BUS_IDLE;
      state_reg.wait_req <= 1'b1;
      state_reg.rdata <= amsf_pkg::DATA_ZERO;
      state_reg.spd <= amsf_pkg::AXES_CLEAR;
      state_reg.decel <= amsf_pkg::AXES_CLEAR;
      state_reg.zero <= amsf_pkg::AXES_CLEAR;
      state_reg.loop_mon <= amsf_pkg::AXES_CLEAR;
      state_reg.loop_cmd <= amsf_pkg::AXES_CLEAR;
      state_reg.start_acc <= amsf_pkg::AXES_CLEAR;
      state_reg.inhibit <= amsf_pkg::AXES_CLEAR;
      state_reg.variant <= amsf_pkg::VARIANT_32;
      state_reg.status <= amsf_pkg::IRQ_CLEAR_VAL;
      state_reg.enable <= amsf_pkg::IRQ_CLEAR_VAL;
      state_reg.irq <= 1'b0;
    end else begin
      state_reg <= state_next;
    end
  end

  // Outputs straight from the state register
  assign avs_readdata = state_reg.rdata;
  assign avs_waitrequest = state_reg.wait_req;
  assign speed_change_accepted_flag = state_reg.spd;
  assign auto_decelerating_flag = state_reg.decel;
  assign zero_speed_accepted_flag = state_reg.zero;
  assign loop_mode_monitor_flag = state_reg.loop_mon;
  assign loop_change_command = state_reg.loop_cmd;
  assign start_accepted_flag = state_reg.start_acc;
  assign restart_inhibit = state_reg.inhibit;
  assign irq = state_reg.irq;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_spd_set: assert property (
    @(posedge sys_clk) disable iff (rst)
    op_cycle_tick |=> ((state_reg.spd & $past(program_speed_change_instruction & axis_mask(state_reg.variant)))
                       == $past(program_speed_change_instruction & axis_mask(state_reg.variant))))
    else $error("program speed change did not set flag");

  a_plc_no_set: assert property (
    @(posedge sys_clk) disable iff (rst)
    op_cycle_tick |=> ((state_reg.spd & $past(plc_side_speed_change_instruction
                        & ~program_speed_change_instruction & ~state_reg.spd)) == '0))
    else $error("PLC-side speed change set flag");

  a_decel_suppr: assert property (
    @(posedge sys_clk) disable iff (rst)
    op_cycle_tick |=> ((state_reg.decel & $past(jog_release_decel | pulse_generator_active
                        | stop_decel | zero_travel)) == '0))
    else $error("decel flag set in suppressed case");

  a_decel_final: assert property (
    @(posedge sys_clk) disable iff (rst)
    op_cycle_tick |=> ((state_reg.decel & $past(const_speed_mode & ~final_point)) == '0))
    else $error("decel flag set at intermediate point");

  a_decel_done: assert property (
    @(posedge sys_clk) disable iff (rst)
    op_cycle_tick |=> ((state_reg.decel & $past(start_complete)) == '0))
    else $error("decel flag survived completion");

  a_zero_refuse: assert property (
    @(posedge sys_clk) disable iff (rst)
    (op_cycle_tick && interp_active == '0) |=> ((state_reg.zero & ~$past(state_reg.zero)
      & $past(jog_release_decel | stop_decel | (state_reg.decel & ~followup_mode))) == '0))
    else $error("refused zero request was accepted");

  a_zero_clear: assert property (
    @(posedge sys_clk) disable iff (rst)
    (op_cycle_tick && zero_speed_request == '0) |=> ((state_reg.zero & $past(stop_cause_done)) == '0))
    else $error("zero flag survived stop completion");

  a_start_hold: assert property (
    @(posedge sys_clk) disable iff (rst)
    ##1 ((state_reg.zero & ~state_reg.start_acc) == '0))
    else $error("start flag dropped while zero request held");

  a_loop_follow: assert property (
    @(posedge sys_clk) disable iff (rst)
    (op_cycle_tick && $stable(state_reg.variant)) |=> (state_reg.loop_mon
      == $past(state_reg.loop_cmd & axis_mask(state_reg.variant))))
    else $error("loop monitor does not follow command");

  a_flags_hold: assert property (
    @(posedge sys_clk) disable iff (rst)
    !op_cycle_tick |=> ($stable(state_reg.spd) && $stable(state_reg.decel) && $stable(state_reg.zero)))
    else $error("flags changed outside operation cycle");

  a_axis_mask: assert property (
    @(posedge sys_clk) disable iff (rst)
    (op_cycle_tick && $stable(state_reg.variant)) |=> ((state_reg.zero | state_reg.spd | state_reg.decel)
      & ~$past(axis_mask(state_reg.variant))) == '0)
    else $error("flag set on axis outside variant");

  a_decel_addr: assert property (
    @(posedge sys_clk) disable iff (rst)
    op_cycle_tick |=> ((state_reg.decel & $past(followup_mode & command_address_change)) == '0))
    else $error("decel flag survived command address change");

  a_zero_accept: assert property (
    @(posedge sys_clk) disable iff (rst)
    op_cycle_tick |=> ((~state_reg.zero & $past(zero_speed_request & axis_started & axis_mask(state_reg.variant)
      & ~(jog_release_decel | stop_decel | (state_reg.decel & ~followup_mode)))) == '0))
    else $error("accepted zero request did not set flag");

  a_zero_group: assert property (
    @(posedge sys_clk) disable iff (rst)
    (op_cycle_tick && ((zero_speed_request & axis_started & interp_active
      & ~(jog_release_decel | stop_decel | (state_reg.decel & ~followup_mode))) != '0))
      |=> ((~state_reg.zero & $past(interp_active & axis_mask(state_reg.variant))) == '0))
    else $error("interpolation group missing zero flag");

  a_inhibit_hold: assert property (
    @(posedge sys_clk) disable iff (rst)
    op_cycle_tick |=> ((state_reg.zero & ~state_reg.inhibit) == '0))
    else $error("restart allowed while zero request held");

  a_bus_answer: assert property (
    @(posedge sys_clk) disable iff (rst)
    ((avs_read || avs_write) && state_reg.bus == AMSF_BUS_IDLE) |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("bus answer not one cycle");

endmodule
